// ==== design/mtcs_defines.svh ====
`ifndef MTCS_DEFINES_SVH
`define MTCS_DEFINES_SVH

// ==========================================================
// Register indices; the byte address of a register is four times its index.
`define MTCS_IDX_CMD 6'h00
`define MTCS_IDX_OUTCOME 6'h04
`define MTCS_IDX_COLCNT 6'h05
`define MTCS_IDX_SETUP 6'h0D
`define MTCS_IDX_ENGINE 6'h10

// ==========================================================
// Field positions of transmit_setup.
`define MTCS_SETUP_CRC_INHIBIT 0
`define MTCS_SETUP_LB_LOW 1
`define MTCS_SETUP_LB_HIGH 2
`define MTCS_SETUP_REMOTE_TX_DIS 3
`define MTCS_SETUP_COL_OFFSET 4

// ==========================================================
// Field positions of transmit_outcome.
`define MTCS_OUT_SENT 0
`define MTCS_OUT_COLLIDED 2
`define MTCS_OUT_ABORTED 3
`define MTCS_OUT_CARRIER_LOST 4
`define MTCS_OUT_UNDERRUN 5
`define MTCS_OUT_HB_MISSING 6
`define MTCS_OUT_LATE_COL 7

// ==========================================================
// Field positions of the command and engine registers.
`define MTCS_CMD_START 0
`define MTCS_ENG_BUSY 0
`define MTCS_ENG_REMOTE_OFF 1
`define MTCS_ENG_PENDING 2

// ==========================================================
// Reset values.
`define MTCS_SETUP_RST 8'h00
`define MTCS_OUTCOME_RST 8'h00
`define MTCS_LFSR_SEED 16'hACE1

// ==========================================================
// Timing and protocol counts.
`define MTCS_CLK_PERIOD_NS 4
`define MTCS_SLOT_TIME_NS 51200
`define MTCS_HB_WINDOW_NS 6400
`define MTCS_SLOT_CYCLES (`MTCS_SLOT_TIME_NS / `MTCS_CLK_PERIOD_NS)
`define MTCS_HB_CYCLES (`MTCS_HB_WINDOW_NS / `MTCS_CLK_PERIOD_NS)
`define MTCS_MAX_ATTEMPTS 16
`define MTCS_BACKOFF_LIMIT 10
`define MTCS_COLLISION_OFFSET_ENABLE_COLLISIONS 3
`define MTCS_COLLISION_OFFSET_ENABLE_BASE 3
`define MTCS_HASH_DISABLE 6'h3E
`define MTCS_HASH_ENABLE 6'h3F

`endif

// ==== design/mtcs_pkg.sv ====
// ==========================================================
// Types shared by the transmit configuration and status block.
package mtcs_pkg;

   // Transmit sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEFER = 3'b001,
      ST_XMIT = 3'b010,
      ST_BACKOFF = 3'b011
   } mtcs_state_t;

   // Loopback field encodings.
   typedef enum logic [1:0] {
      LB_NORMAL = 2'b00,
      LB_CORE = 2'b01,
      LB_CODEC = 2'b10,
      LB_EXTERNAL = 2'b11
   } mtcs_lb_mode_t;

endpackage : mtcs_pkg

// ==== design/mtcs_top.sv ====
// Functional notes
// - Loopback bits reset to zero, normal mode.
// - CRC inhibit bit drops FCS, also in loopback.
// - Loopback field selects one of four modes.
// - Codec loopback flag high only in mode 2.
// - Hash 62 disables, hash 63 enables transmitter.
// - Clearing remote disable bit re-enables transmitter.
// - Offset mode: first three backoffs use 2^min(3+n,10).
// - Outcome register cleared when host starts transmission.
// - Outcome bits set only by real events.
// - Sent flag only without abort or underrun.
// - Collided flag plus collision count register.
// - Sixteen attempts by collisions abort the frame.
// - Carrier loss flagged outside core loopback, frame still completes.
// - FIFO underrun flagged and frame aborted.
// - No heartbeat within 6.4 us sets flag.
// - Heartbeat flag may set after collisions.
// - Collision after one slot sets late flag.
`timescale 1ns/1ns
`default_nettype none
`include "mtcs_defines.svh"

module mtcs_top #(
   parameter int SLOT_CYCLES = `MTCS_SLOT_CYCLES,
   parameter int HB_CYCLES = `MTCS_HB_CYCLES,
   parameter int MAX_ATTEMPTS = `MTCS_MAX_ATTEMPTS
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Avalon-MM register slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Medium and transmit datapath events.
   input wire logic col_det,
   input wire logic carrier_sense,
   input wire logic frame_last,
   input wire logic fifo_starved,
   // Receive-side multicast hash report.
   input wire logic rx_mcast_hit,
   input wire logic [5:0] rx_hash_index,
   // Controls to the transmit datapath and codec.
   output logic tx_run,
   output logic tx_done,
   output logic tx_crc_append,
   output logic [1:0] loopback_mode,
   output logic codec_loopback_flag
);

   // ==========================================================
   // Constants sized to the counters they meet.
   // Sixteen-bit counters hold a full slot and window at this clock.
   localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);
   localparam logic [15:0] HB_LAST = 16'(HB_CYCLES - 1);
   localparam logic [4:0] ATTEMPT_MAX = 5'(MAX_ATTEMPTS);
   localparam logic [4:0] COLLISION_OFFSET_ENABLE_N = 5'(`MTCS_COLLISION_OFFSET_ENABLE_COLLISIONS);
   localparam logic [4:0] COLLISION_OFFSET_ENABLE_BASE = 5'(`MTCS_COLLISION_OFFSET_ENABLE_BASE);
   localparam logic [4:0] EXP_LIMIT = 5'(`MTCS_BACKOFF_LIMIT);

   // ==========================================================
   // Functions.

   // True when a byte address falls on the word of a register index.
   // Address bits 1:0 are ignored, so each register fills one aligned word.
   function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
      reg_hit = (addr[7:2] == idx);
   endfunction : reg_hit

   // Backoff exponent after n collisions, with or without the offset.
   function automatic logic [4:0] backoff_exp(input logic [4:0] n, input logic collision_offset_enable);
      logic [4:0] e;
      e = (n > EXP_LIMIT) ? EXP_LIMIT : n;
      if (collision_offset_enable && (n <= COLLISION_OFFSET_ENABLE_N)) begin
         e = ((n + COLLISION_OFFSET_ENABLE_BASE) > EXP_LIMIT) ? EXP_LIMIT : 5'(n + COLLISION_OFFSET_ENABLE_BASE);
      end
      backoff_exp = e;
   endfunction : backoff_exp

   // ==========================================================
   // Declarations.
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] setup_reg, setup_next;
   logic crc_app_reg, crc_app_next;
   logic codec_lb_reg, codec_lb_next;
   logic remote_off_reg, remote_off_next;
   logic [15:0] lfsr_reg, lfsr_next;
   mtcs_pkg::mtcs_state_t state_reg, state_next;
   logic [15:0] cyc_reg, cyc_next;
   logic [9:0] slots_reg, slots_next;
   logic [4:0] colcnt_reg, colcnt_next;
   logic [7:0] outcome_reg, outcome_next;
   logic pending_reg, pending_next;
   logic run_reg, run_next;
   logic done_reg, done_next;
   logic hb_active_reg, hb_active_next;
   logic [15:0] hb_cnt_reg, hb_cnt_next;
   logic hb_seen_reg, hb_seen_next;
   logic col_prev_reg, col_prev_next;
   logic bus_take;
   logic busy;
   logic start_cmd;

   // ==========================================================
   // Bus slave: a request is taken when waitrequest is low.
   assign bus_take = (avs_read || avs_write) && !wait_reg;
   // Busy covers the heartbeat window, whose flag still belongs to the last frame.
   assign busy = pending_reg || (state_reg != mtcs_pkg::ST_IDLE) || hb_active_reg;
   // A start while the engine is busy is dropped so a running frame keeps its outcome.
   assign start_cmd = bus_take && avs_write && avs_byteenable[0] &&
      reg_hit(avs_address, `MTCS_IDX_CMD) && avs_writedata[`MTCS_CMD_START] && !busy;

   // One wait state: waitrequest drops for exactly one cycle per request.
   // A registered answer costs a cycle but keeps the decode off the bus path.
   always_comb begin
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      if ((avs_read || avs_write) && wait_reg) begin
         wait_next = 1'b0;
         rdata_next = 32'h00000000;
         if (avs_read) begin
            if (reg_hit(avs_address, `MTCS_IDX_OUTCOME)) begin
               rdata_next = {24'h000000, outcome_reg};
            end else if (reg_hit(avs_address, `MTCS_IDX_COLCNT)) begin
               rdata_next = {27'h0000000, colcnt_reg};
            end else if (reg_hit(avs_address, `MTCS_IDX_ENGINE)) begin
               rdata_next = {29'h00000000, pending_reg, remote_off_reg, busy};
            end
         end
      end
   end

   // Bus answer registers.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Configuration: transmit_setup, derived controls and remote disable.
   always_comb begin
      setup_next = setup_reg;
      // Reserved bits 7:5 are dropped on write.
      if (bus_take && avs_write && avs_byteenable[0] &&
          reg_hit(avs_address, `MTCS_IDX_SETUP)) begin
         setup_next = {3'b000, avs_writedata[4:0]};
      end
      // The CRC choice is not gated by loopback so the CRC path can be tested there.
      crc_app_next = !setup_next[`MTCS_SETUP_CRC_INHIBIT];
      codec_lb_next = (setup_next[`MTCS_SETUP_LB_HIGH:`MTCS_SETUP_LB_LOW] ==
         mtcs_pkg::LB_CODEC);
      remote_off_next = remote_off_reg;
      // Remote frames only count while the enable bit is set; clearing it wins.
      if (!setup_reg[`MTCS_SETUP_REMOTE_TX_DIS]) begin
         remote_off_next = 1'b0;
      end else if (rx_mcast_hit && (rx_hash_index == `MTCS_HASH_DISABLE)) begin
         remote_off_next = 1'b1;
      end else if (rx_mcast_hit && (rx_hash_index == `MTCS_HASH_ENABLE)) begin
         remote_off_next = 1'b0;
      end
      // Free-running generator for backoff draws.
      // It steps in every state so that back-to-back draws differ.
      lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
   end

   // Configuration registers; loopback powers up in normal mode.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         setup_reg <= `MTCS_SETUP_RST;
         crc_app_reg <= 1'b1;
         codec_lb_reg <= 1'b0;
         remote_off_reg <= 1'b0;
         lfsr_reg <= `MTCS_LFSR_SEED;
      end else begin
         setup_reg <= setup_next;
         crc_app_reg <= crc_app_next;
         codec_lb_reg <= codec_lb_next;
         remote_off_reg <= remote_off_next;
         lfsr_reg <= lfsr_next;
      end
   end

   // ==========================================================
   // Transmit sequencer, outcome flags and heartbeat window.
   always_comb begin
      logic [7:0] set_bits;
      logic [4:0] n;
      logic [4:0] e;
      logic hb_start;
      logic hb_rise;
      set_bits = 8'h00;
      n = 5'(colcnt_reg + 5'h01);
      e = backoff_exp(n, setup_reg[`MTCS_SETUP_COL_OFFSET]);
      hb_start = 1'b0;
      hb_rise = col_det && !col_prev_reg;
      state_next = state_reg;
      cyc_next = cyc_reg;
      slots_next = slots_reg;
      colcnt_next = colcnt_reg;
      pending_next = pending_reg;
      run_next = 1'b0;
      done_next = 1'b0;
      col_prev_next = col_det;
      hb_active_next = hb_active_reg;
      hb_cnt_next = hb_cnt_reg;
      hb_seen_next = hb_seen_reg;

      // A host start clears all outcome state for the new transmission.
      // A dropped start leaves the previous outcome readable.
      if (start_cmd) begin
         pending_next = 1'b1;
         colcnt_next = 5'h00;
      end

      case (state_reg)
         mtcs_pkg::ST_IDLE: begin
            // A remotely disabled transmitter keeps the request pending.
            if (pending_reg && !remote_off_reg && !hb_active_reg) begin
               pending_next = 1'b0;
               state_next = mtcs_pkg::ST_DEFER;
            end
         end
         mtcs_pkg::ST_DEFER: begin
            // Every attempt, a retry too, waits for a quiet medium.
            if (!carrier_sense) begin
               state_next = mtcs_pkg::ST_XMIT;
               cyc_next = 16'h0000;
               run_next = 1'b1;
            end
         end
         mtcs_pkg::ST_XMIT: begin
            run_next = 1'b1;
            if (cyc_reg != 16'hFFFF) begin
               cyc_next = 16'(cyc_reg + 16'h0001);
            end
            if (col_det) begin
               run_next = 1'b0;
               hb_start = 1'b1;
               colcnt_next = n;
               set_bits[`MTCS_OUT_COLLIDED] = 1'b1;
               if (cyc_reg >= SLOT_LAST) begin
                  set_bits[`MTCS_OUT_LATE_COL] = 1'b1;
               end
               // The count keeps its last value, so software reads sixteen after an abort.
               if (n >= ATTEMPT_MAX) begin
                  set_bits[`MTCS_OUT_ABORTED] = 1'b1;
                  done_next = 1'b1;
                  state_next = mtcs_pkg::ST_IDLE;
               end else begin
                  // Late collisions are rescheduled exactly like early ones.
                  slots_next = lfsr_reg[9:0] & 10'((11'h001 << e) - 11'h001);
                  cyc_next = 16'h0000;
                  state_next = mtcs_pkg::ST_BACKOFF;
               end
            end else if (fifo_starved) begin
               run_next = 1'b0;
               hb_start = 1'b1;
               set_bits[`MTCS_OUT_UNDERRUN] = 1'b1;
               done_next = 1'b1;
               state_next = mtcs_pkg::ST_IDLE;
            end else if (frame_last) begin
               run_next = 1'b0;
               hb_start = 1'b1;
               done_next = 1'b1;
               if (!outcome_reg[`MTCS_OUT_ABORTED] && !outcome_reg[`MTCS_OUT_UNDERRUN]) begin
                  set_bits[`MTCS_OUT_SENT] = 1'b1;
               end
               state_next = mtcs_pkg::ST_IDLE;
            end else if (!carrier_sense &&
               (setup_reg[`MTCS_SETUP_LB_HIGH:`MTCS_SETUP_LB_LOW] != mtcs_pkg::LB_CORE)) begin
               // Core loopback never sees carrier, so it would flag every frame.
               set_bits[`MTCS_OUT_CARRIER_LOST] = 1'b1;
            end
         end
         mtcs_pkg::ST_BACKOFF: begin
            // Each slot is counted out in full; a zero draw retries at once.
            if (slots_reg == 10'h000) begin
               state_next = mtcs_pkg::ST_DEFER;
            end else if (cyc_reg >= SLOT_LAST) begin
               cyc_next = 16'h0000;
               slots_next = 10'(slots_reg - 10'h001);
            end else begin
               cyc_next = 16'(cyc_reg + 16'h0001);
            end
         end
         default: begin
            state_next = mtcs_pkg::ST_IDLE;
         end
      endcase

      // The window only counts a heartbeat that starts inside it; a collision that
      // is still active when the attempt ends does not count, so such attempts may
      // flag a missing heartbeat.
      // Starts wait for the window so a late flag never lands on the next frame.
      if (hb_active_reg) begin
         if (hb_rise) begin
            hb_seen_next = 1'b1;
         end
         if (hb_cnt_reg >= HB_LAST) begin
            hb_active_next = 1'b0;
            if (!hb_seen_reg && !hb_rise) begin
               set_bits[`MTCS_OUT_HB_MISSING] = 1'b1;
            end
         end else begin
            hb_cnt_next = 16'(hb_cnt_reg + 16'h0001);
         end
      end
      if (hb_start) begin
         hb_active_next = 1'b1;
         hb_cnt_next = 16'h0000;
         hb_seen_next = 1'b0;
      end

      // Only events set bits; a set arriving with a clear is kept.
      outcome_next = (start_cmd ? 8'h00 : outcome_reg) | set_bits;
   end

   // Sequencer registers.
   // A reset in mid-frame returns every register to its idle value.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_reg <= mtcs_pkg::ST_IDLE;
         cyc_reg <= 16'h0000;
         slots_reg <= 10'h000;
         colcnt_reg <= 5'h00;
         outcome_reg <= `MTCS_OUTCOME_RST;
         pending_reg <= 1'b0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
         hb_active_reg <= 1'b0;
         hb_cnt_reg <= 16'h0000;
         hb_seen_reg <= 1'b0;
         col_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cyc_reg <= cyc_next;
         slots_reg <= slots_next;
         colcnt_reg <= colcnt_next;
         outcome_reg <= outcome_next;
         pending_reg <= pending_next;
         run_reg <= run_next;
         done_reg <= done_next;
         hb_active_reg <= hb_active_next;
         hb_cnt_reg <= hb_cnt_next;
         hb_seen_reg <= hb_seen_next;
         col_prev_reg <= col_prev_next;
      end
   end

   // ==========================================================
   // Outputs, each straight from a flip-flop.
   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;
   assign tx_run = run_reg;
   assign tx_done = done_reg;
   assign tx_crc_append = crc_app_reg;
   // The codec flag has its own register beside the stored loopback field.
   assign loopback_mode = setup_reg[`MTCS_SETUP_LB_HIGH:`MTCS_SETUP_LB_LOW];
   assign codec_loopback_flag = codec_lb_reg;

endmodule : mtcs_top
`default_nettype wire

// ==== tb/mtcs_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port-level checks of the transmit setup and outcome block.
module mtcs_props #(
   parameter int SLOT_CYCLES = 16,
   parameter int HB_CYCLES = 8,
   parameter int MAX_ATTEMPTS = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register bus.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   // Medium events.
   input wire logic col_det,
   input wire logic frame_last,
   input wire logic fifo_starved,
   // Transmit controls.
   input wire logic tx_run,
   input wire logic tx_done,
   input wire logic tx_crc_append,
   input wire logic [1:0] loopback_mode,
   input wire logic codec_loopback_flag
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // A setup write lands at the edge where waitrequest is low.
   sequence s_setup_wr;
      avs_write && !avs_waitrequest && avs_address[7:2] == 6'h0D;
   endsequence
   // An attempt ends cleanly on the last bit of the frame.
   sequence s_frame_end;
      tx_run && frame_last && !col_det && !fifo_starved;
   endsequence
   // Each request gets exactly one wait state, then a one-cycle answer.
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer after one wait state");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_reset_normal: assert property ($rose(rst_b) |-> loopback_mode == 2'b00)
      else $error("loopback not normal after reset");
   a_setup_fields: assert property (s_setup_wr |=>
      loopback_mode == $past(avs_writedata[2:1]) && tx_crc_append == !$past(avs_writedata[0]))
      else $error("setup fields not applied");
   a_codec_mode: assert property ($stable(loopback_mode) |->
      codec_loopback_flag == (loopback_mode == 2'b10))
      else $error("codec loopback flag wrong");
   a_frame_done: assert property (s_frame_end |=> tx_done && !tx_run)
      else $error("frame end not reported");
   a_starve_abort: assert property (tx_run && fifo_starved && !col_det |=> tx_done && !tx_run)
      else $error("underrun did not abort");
   a_col_stop: assert property (tx_run && col_det |=> !tx_run)
      else $error("collision did not stop attempt");
   a_carrier_keep: assert property (tx_run && !col_det && !fifo_starved && !frame_last |=> tx_run)
      else $error("attempt stopped without cause");
   a_done_pulse: assert property (tx_done |=> !tx_done)
      else $error("done longer than one cycle");
endmodule : mtcs_props
bind mtcs_top mtcs_props #(
   .SLOT_CYCLES(SLOT_CYCLES), .HB_CYCLES(HB_CYCLES), .MAX_ATTEMPTS(MAX_ATTEMPTS)
) i_props (
   .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .col_det(col_det), .frame_last(frame_last), .fifo_starved(fifo_starved), .tx_run(tx_run),
   .tx_done(tx_done), .tx_crc_append(tx_crc_append), .loopback_mode(loopback_mode),
   .codec_loopback_flag(codec_loopback_flag)
);
`default_nettype wire

// ==== tb/mtcs_medium_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Shared medium: collisions, own-carrier echo, frame end and heartbeat.
module mtcs_medium_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Transmitter as seen on the wire.
   input wire logic tx_run,
   input wire logic tx_done,
   // Scenario controls.
   input wire logic [7:0] colls,
   input wire logic [7:0] col_at,
   input wire logic starve,
   input wire logic drop_carrier,
   input wire logic hb_en,
   // Medium events.
   output logic col_det,
   output logic carrier_sense,
   output logic frame_last,
   output logic fifo_starved
);
   localparam int FRAME_LEN = 40;
   int cnt;
   int ncol;
   int hb_cnt;
   // Carrier echoes our own signal; a drop midway mimics a lost carrier.
   assign carrier_sense = tx_run && !(drop_carrier && cnt > 8);
   // Collisions hold until the attempt stops, so no fresh edge reaches the window.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt <= 0;
         ncol <= 0;
         hb_cnt <= 0;
         col_det <= 1'b0;
         frame_last <= 1'b0;
         fifo_starved <= 1'b0;
      end else begin
         frame_last <= 1'b0;
         fifo_starved <= 1'b0;
         cnt <= tx_run ? cnt + 1 : 0;
         hb_cnt <= tx_done ? 1 : (hb_cnt > 0 && hb_cnt < 8) ? hb_cnt + 1 : 0;
         if (tx_done) ncol <= 0;
         if (tx_run && ncol < int'(colls) && cnt == int'(col_at)) begin
            col_det <= 1'b1;
            ncol <= ncol + 1;
         end else if (hb_en && hb_cnt == 2) col_det <= 1'b1;
         else if (!tx_run && hb_cnt != 3) col_det <= 1'b0;
         if (tx_run && ncol >= int'(colls) && cnt == FRAME_LEN) begin
            fifo_starved <= starve;
            frame_last <= !starve;
         end
      end
   end
endmodule : mtcs_medium_model
`default_nettype wire

// ==== tb/mac_transmit_config_status_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Register-level tests of transmit setup, outcome and medium events.
module mac_transmit_config_status_bench;
   localparam int HB = 8;
   logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address, m_colls, m_col_at;
   logic [31:0] avs_writedata, avs_readdata, v;
   logic col_det, carrier_sense, frame_last, fifo_starved, rx_mcast_hit;
   logic [5:0] rx_hash_index;
   logic tx_run, tx_done, tx_crc_append, codec_loopback_flag, m_starve, m_drop, m_hb;
   logic [1:0] loopback_mode;
   int bad_count, checks_done;
   // Short slot and window keep the sixteen-attempt case affordable.
   mtcs_top #(.SLOT_CYCLES(8), .HB_CYCLES(HB), .MAX_ATTEMPTS(16)) i_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .col_det(col_det),
      .carrier_sense(carrier_sense), .frame_last(frame_last), .fifo_starved(fifo_starved),
      .rx_mcast_hit(rx_mcast_hit), .rx_hash_index(rx_hash_index), .tx_run(tx_run),
      .tx_done(tx_done), .tx_crc_append(tx_crc_append), .loopback_mode(loopback_mode),
      .codec_loopback_flag(codec_loopback_flag)
   );
   mtcs_medium_model i_medium (
      .clk_sys(clk_sys), .rst_b(rst_b), .tx_run(tx_run), .tx_done(tx_done), .colls(m_colls),
      .col_at(m_col_at), .starve(m_starve), .drop_carrier(m_drop), .hb_en(m_hb),
      .col_det(col_det), .carrier_sense(carrier_sense), .frame_last(frame_last),
      .fifo_starved(fifo_starved)
   );
   // Clock at 4 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Verdict, printed once.
   task automatic final_report;
      $display("Mismatches %0d, checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One bus cycle; a spare edge after release avoids re-raising in the same step.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 64) begin
         @(posedge clk_sys);
         n++;
      end
      v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      if (n == 64) begin
         bad_count++;
         final_report();
      end
   endtask : bus
   // Waits for the end of a transmission, then lets the heartbeat window close.
   task automatic wait_done;
      int n;
      n = 0;
      while (tx_done !== 1'b1 && n < 80000) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (HB + 4) @(posedge clk_sys);
      if (n == 80000) begin
         bad_count++;
         final_report();
      end
   endtask : wait_done
   task automatic mcast(input logic [5:0] h);
      rx_hash_index <= h;
      rx_mcast_hit <= 1'b1;
      @(posedge clk_sys);
      rx_mcast_hit <= 1'b0;
      @(posedge clk_sys);
   endtask : mcast
   // Events ev are {heartbeat, carrier drop, underrun}.
   task automatic frame(input logic [7:0] nc, ca, input logic [2:0] ev,
                        input logic [7:0] msk, exp, cnt);
      m_colls <= nc;
      m_col_at <= ca;
      {m_hb, m_drop, m_starve} <= ev;
      bus(1'b1, 8'h00, 8'h01);
      wait_done();
      bus(1'b0, 8'h10, 8'h00);
      check("outcome", v & {24'h000000, msk}, {24'h000000, exp});
      bus(1'b0, 8'h14, 8'h00);
      check("collisions", v, {24'h000000, cnt});
   endtask : frame
   // Main sequence.
   initial begin
      {rst_b, avs_read, avs_write, rx_mcast_hit, m_starve, m_drop, m_hb} <= 7'h00;
      {avs_address, m_colls, m_col_at, rx_hash_index} <= 30'h0;
      avs_writedata <= 32'h0;
      bad_count = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      check("lb reset", {30'h0, loopback_mode}, 32'h0);
      check("crc reset", {31'h0, tx_crc_append}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         // The data setup loopback bit lies outside this block; host clears it there.
         bus(1'b1, 8'h34, 8'(i));
         @(posedge clk_sys);
         check("lb", {30'h0, loopback_mode}, 32'(i[2:1]));
         check("codec", {31'h0, codec_loopback_flag}, {31'h0, i[2:1] == 2'b10});
         check("crc", {31'h0, tx_crc_append}, {31'h0, !i[0]});
      end
      bus(1'b0, 8'h34, 8'h00);
      check("setup read", v, 32'h0);
      bus(1'b0, 8'hFC, 8'h00);
      check("unmapped", v, 32'h0);
      bus(1'b1, 8'h34, 8'h00);
      frame(8'd0, 8'd0, 3'b100, 8'hFF, 8'h01, 8'h00);
      frame(8'd0, 8'd0, 3'b010, 8'hFF, 8'h51, 8'h00);
      frame(8'd0, 8'd0, 3'b101, 8'hFF, 8'h20, 8'h00);
      frame(8'd2, 8'd5, 3'b100, 8'hBF, 8'h05, 8'h02);
      frame(8'd1, 8'd20, 3'b100, 8'hFF, 8'hC5, 8'h01);
      frame(8'd16, 8'd5, 3'b100, 8'hBF, 8'h0C, 8'h10);
      bus(1'b1, 8'h34, 8'h10);
      frame(8'd3, 8'd5, 3'b100, 8'hBF, 8'h05, 8'h03);
      bus(1'b1, 8'h34, 8'h08);
      mcast(6'h3E);
      bus(1'b1, 8'h00, 8'h01);
      repeat (40) @(posedge clk_sys);
      check("held", {31'h0, tx_run}, 32'h0);
      bus(1'b0, 8'h40, 8'h00);
      check("remote off", v & 32'h2, 32'h2);
      mcast(6'h3F);
      wait_done();
      mcast(6'h3E);
      bus(1'b1, 8'h00, 8'h01);
      repeat (40) @(posedge clk_sys);
      bus(1'b1, 8'h34, 8'h00);
      wait_done();
      bus(1'b0, 8'h40, 8'h00);
      check("remote on", v & 32'h2, 32'h0);
      final_report();
   end
endmodule : mac_transmit_config_status_bench
`default_nettype wire
